/* File: inc/ebarb_pkg.sv */
// Shared types and constants of the external bus arbitration link
package ebarb_pkg;

    // Bus widths
    localparam int EBARB_ADDR_W = 32;
    localparam int EBARB_DATA_W = 32;
    localparam int EBARB_BEAT_W = 5;
    localparam int EBARB_DIV_W = 8;

    // Bus clock divider default: sys_clk cycles per bus_clock_out period
    localparam int EBARB_BUS_DIV_DEF = 4;

    // Beat counts of the data phase forms
    localparam logic [EBARB_BEAT_W-1:0] EBARB_BEATS_SINGLE = 5'h01;
    localparam logic [EBARB_BEAT_W-1:0] EBARB_BEATS_BURST4 = 5'h04;
    localparam logic [EBARB_BEAT_W-1:0] EBARB_BEATS_BURST8 = 5'h08;
    localparam logic [EBARB_BEAT_W-1:0] EBARB_BEATS_BURST16 = 5'h10;
    localparam logic [EBARB_BEAT_W-1:0] EBARB_BEAT_ONE = 5'h01;

    // Data phase forms
    typedef enum logic [1:0] {
        EBARB_SINGLE = 2'h0,
        EBARB_BURST4 = 2'h1,
        EBARB_BURST8 = 2'h2,
        EBARB_BURST16 = 2'h3
    } ebarb_kind_t;

    // Transfer attributes presented in the address phase
    typedef struct packed {
        logic has_data;
        ebarb_kind_t kind;
    } ebarb_attr_t;

    // Transaction phases
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_ARB = 3'h1,
        ST_ADDR = 3'h2,
        ST_DATA = 3'h3,
        ST_TERM = 3'h4
    } ebarb_state_t;

    function automatic logic [EBARB_BEAT_W-1:0] ebarb_beats(input ebarb_kind_t k);
        logic [EBARB_BEAT_W-1:0] n;
        n = EBARB_BEATS_SINGLE;
        unique case (k)
            EBARB_SINGLE: n = EBARB_BEATS_SINGLE;
            EBARB_BURST4: n = EBARB_BEATS_BURST4;
            EBARB_BURST8: n = EBARB_BEATS_BURST8;
            EBARB_BURST16: n = EBARB_BEATS_BURST16;
        endcase
        return n;
    endfunction

endpackage

/* File: inc/ebarb_if.sv */
// Shared bus wires between the device end and the far end
interface ebarb_if import ebarb_pkg::*; ();
    // Bus clock made by the device
    logic bus_clock_out;
    // Open-drain arbitration pins, per driver
    logic dev_br_o;
    logic dev_br_oe;
    logic far_br_o;
    logic far_br_oe;
    logic dev_bg_o;
    logic dev_bg_oe;
    logic far_bg_o;
    logic far_bg_oe;
    logic dev_bb_o;
    logic dev_bb_oe;
    logic far_bb_o;
    logic far_bb_oe;
    // Transfer framing, driven by the owner
    logic dev_own_oe;
    logic dev_start_n_o;
    logic dev_beat_n_o;
    logic [EBARB_ADDR_W-1:0] dev_addr_o;
    ebarb_attr_t dev_attr_o;
    logic [EBARB_DATA_W-1:0] dev_data_o;
    logic far_own_oe;
    logic far_start_n_o;
    logic far_beat_n_o;
    logic [EBARB_ADDR_W-1:0] far_addr_o;
    ebarb_attr_t far_attr_o;
    logic [EBARB_DATA_W-1:0] far_data_o;
    // Resolved levels
    logic bus_request_n;
    logic bus_grant_n;
    logic bus_busy_n;
    logic bus_start_n;
    logic bus_beat_n;
    logic [EBARB_ADDR_W-1:0] bus_addr;
    ebarb_attr_t bus_attr;
    logic [EBARB_DATA_W-1:0] bus_data;

    // Pull-ups hold the active-low lines high when nobody pulls them
    assign bus_request_n = ~((dev_br_oe & ~dev_br_o) | (far_br_oe & ~far_br_o));
    assign bus_grant_n = ~((dev_bg_oe & ~dev_bg_o) | (far_bg_oe & ~far_bg_o));
    assign bus_busy_n = ~((dev_bb_oe & ~dev_bb_o) | (far_bb_oe & ~far_bb_o));
    assign bus_start_n = dev_own_oe ? dev_start_n_o : (far_own_oe ? far_start_n_o : 1'b1);
    assign bus_beat_n = dev_own_oe ? dev_beat_n_o : (far_own_oe ? far_beat_n_o : 1'b1);
    assign bus_addr = dev_own_oe ? dev_addr_o : (far_own_oe ? far_addr_o : '0);
    assign bus_attr = dev_own_oe ? dev_attr_o : (far_own_oe ? far_attr_o : '0);
    assign bus_data = dev_own_oe ? dev_data_o : (far_own_oe ? far_data_o : '0);

    modport dev_mp (
        output bus_clock_out,
        output dev_br_o, dev_br_oe, dev_bg_o, dev_bg_oe, dev_bb_o, dev_bb_oe,
        output dev_own_oe, dev_start_n_o, dev_beat_n_o, dev_addr_o, dev_attr_o, dev_data_o,
        input bus_request_n, bus_grant_n, bus_busy_n,
        input bus_start_n, bus_beat_n, bus_addr, bus_attr, bus_data
    );

    modport far_mp (
        input bus_clock_out,
        output far_br_o, far_br_oe, far_bg_o, far_bg_oe, far_bb_o, far_bb_oe,
        output far_own_oe, far_start_n_o, far_beat_n_o, far_addr_o, far_attr_o, far_data_o,
        input bus_request_n, bus_grant_n, bus_busy_n,
        input bus_start_n, bus_beat_n, bus_addr, bus_attr, bus_data
    );
endinterface

/* File: rtl/ebarb_dev.sv */
// Device end: bus clock, internal arbiter or requester, transfer engine
// Notes on behaviour
// R1: Internal arbiter grants bus to external master.
// R2: Master owns bus on grant with busy negated.
// R3: Arbiter off: sample grant when transfer pending.
// R4: Arbiter off: qualify grant with sampled busy.
// R5: Arbiter on: drive busy while device owns.
// R6: Arbiter off: busy only after grant, ready.
// R7: Arbiter on: busy negation ends external tenure.
// R8: Device makes bus clock; bus runs on it.
// R9: All bus signals move on bus clock rise.
// R10: Phases: arbitration, address, data, termination.
// R11: Address phase carries address, attributes; optional data.
// R12: Data: single, 4, 8 or 16 beats.
// R13: External master requests via request line.
// R14: Arbiter off: device drives request while unparked.
// R15: Static arbiter-enable input sets pin directions.
module ebarb_dev import ebarb_pkg::*; #(
    parameter int BUS_DIV = EBARB_BUS_DIV_DEF
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // Configuration
    input wire logic arb_en,
    // Transaction request
    input wire logic req_valid,
    output logic req_ready,
    input wire logic [EBARB_ADDR_W-1:0] req_addr,
    input wire ebarb_attr_t req_attr,
    input wire logic [EBARB_DATA_W-1:0] beat_data,
    output logic beat_take,
    output logic xfer_done,
    // Transfers seen from the other party
    output logic rx_addr_valid,
    output logic [EBARB_ADDR_W-1:0] rx_addr,
    output ebarb_attr_t rx_attr,
    output logic rx_data_valid,
    output logic [EBARB_DATA_W-1:0] rx_data,
    // Bus
    ebarb_if.dev_mp bus
);

    if (BUS_DIV < 2 || BUS_DIV % 2 != 0 || BUS_DIV > 2 ** EBARB_DIV_W) begin : g_bad_div
        $error("BUS_DIV must be even and between 2 and 256");
    end

    localparam logic [EBARB_DIV_W-1:0] DIV_LAST = EBARB_DIV_W'(BUS_DIV - 1);
    localparam logic [EBARB_DIV_W-1:0] DIV_HALF = EBARB_DIV_W'(BUS_DIV / 2);

    typedef struct packed {
        logic [EBARB_DIV_W-1:0] cnt;
        logic clk;
        ebarb_state_t st;
        ebarb_attr_t attr;
        logic [EBARB_ADDR_W-1:0] addr;
        logic [EBARB_DATA_W-1:0] data;
        logic [EBARB_BEAT_W-1:0] left;
        logic grant;
        logic seen;
        logic br;
        logic bb;
        logic own;
        logic start;
        logic beat;
        logic done;
        logic rx_av;
        logic rx_dv;
        logic [EBARB_ADDR_W-1:0] rx_addr;
        ebarb_attr_t rx_attr;
        logic [EBARB_DATA_W-1:0] rx_data;
    } ebarb_dev_t;

    ebarb_dev_t q;
    ebarb_dev_t d;

    logic en;
    logic ext_req;
    logic granted_in;
    logic busy_in;

    // Logic steps in the cycle in which bus_clock_out has just risen
    assign en = (q.cnt == '0); // R9
    assign ext_req = ~bus.bus_request_n;
    assign granted_in = ~bus.bus_grant_n;
    assign busy_in = ~bus.bus_busy_n;

    assign req_ready = en && (q.st == ST_IDLE);
    assign beat_take = en && (((q.st == ST_ADDR) && q.attr.has_data)
                       || ((q.st == ST_DATA) && (q.left != EBARB_BEAT_ONE)));

    always_comb begin
        d = q;
        d.done = 1'b0;
        d.rx_av = 1'b0;
        d.rx_dv = 1'b0;
        // Bus clock divider, high for the first half of each period
        d.cnt = (q.cnt == DIV_LAST) ? '0 : q.cnt + 1'b1; // R8
        d.clk = (d.cnt < DIV_HALF); // R8
        if (en) begin
            // Internal arbiter, active only when enabled
            if (arb_en) begin // R15
                if (!q.grant) begin
                    if (ext_req && !busy_in && q.st == ST_IDLE && !req_valid) begin
                        d.grant = 1'b1; // R1
                    end
                end else if (!q.seen) begin
                    if (busy_in) begin
                        d.seen = 1'b1;
                    end else if (!ext_req) begin
                        d.grant = 1'b0;
                    end
                end else if (!busy_in) begin
                    d.grant = 1'b0; // R7
                    d.seen = 1'b0; // R7
                end
            end else begin
                d.grant = 1'b0;
                d.seen = 1'b0;
            end
            unique case (q.st)
                ST_IDLE: begin
                    if (req_valid) begin
                        d.addr = req_addr;
                        d.attr = req_attr;
                        d.st = ST_ARB; // R10
                    end
                end
                ST_ARB: begin
                    if (arb_en) begin
                        // Parked on the bus: take it once no grant is out and it is free
                        if (!q.grant && !busy_in) begin
                            d.bb = 1'b1; // R5
                            d.own = 1'b1;
                            d.start = 1'b1; // R11
                            d.st = ST_ADDR;
                        end
                    end else begin
                        d.br = 1'b1; // R14
                        if (granted_in && !busy_in) begin // R3 R4
                            d.br = 1'b0;
                            d.bb = 1'b1; // R6
                            d.own = 1'b1;
                            d.start = 1'b1; // R11
                            d.st = ST_ADDR;
                        end
                    end
                end
                ST_ADDR: begin
                    d.start = 1'b0;
                    if (q.attr.has_data) begin // R11
                        d.data = beat_data;
                        d.beat = 1'b1;
                        d.left = ebarb_beats(q.attr.kind); // R12
                        d.st = ST_DATA;
                    end else begin
                        d.st = ST_TERM;
                    end
                end
                ST_DATA: begin
                    if (q.left == EBARB_BEAT_ONE) begin
                        d.beat = 1'b0;
                        d.st = ST_TERM; // R10
                    end else begin
                        d.left = q.left - 1'b1; // R12
                        d.data = beat_data;
                    end
                end
                ST_TERM: begin
                    d.bb = 1'b0;
                    d.own = 1'b0;
                    d.done = 1'b1;
                    d.st = ST_IDLE;
                end
                default: begin
                    d.st = ST_IDLE;
                end
            endcase
            // Watch transfers run by the other party
            if (!q.own && !bus.bus_start_n) begin
                d.rx_av = 1'b1;
                d.rx_addr = bus.bus_addr;
                d.rx_attr = bus.bus_attr;
            end
            if (!q.own && !bus.bus_beat_n) begin
                d.rx_dv = 1'b1;
                d.rx_data = bus.bus_data;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            q <= '0;
            q.cnt <= DIV_LAST;
        end else begin
            q <= d;
        end
    end

    // Pin outputs
    assign bus.bus_clock_out = q.clk; // R8
    assign bus.dev_br_o = 1'b0;
    assign bus.dev_br_oe = q.br;
    assign bus.dev_bg_o = 1'b0;
    assign bus.dev_bg_oe = q.grant; // R1
    assign bus.dev_bb_o = 1'b0;
    assign bus.dev_bb_oe = q.bb;
    assign bus.dev_own_oe = q.own;
    assign bus.dev_start_n_o = ~q.start;
    assign bus.dev_beat_n_o = ~q.beat;
    assign bus.dev_addr_o = q.addr;
    assign bus.dev_attr_o = q.attr;
    assign bus.dev_data_o = q.data;

    // User outputs
    assign xfer_done = q.done;
    assign rx_addr_valid = q.rx_av;
    assign rx_addr = q.rx_addr;
    assign rx_attr = q.rx_attr;
    assign rx_data_valid = q.rx_dv;
    assign rx_data = q.rx_data;

endmodule

/* File: rtl/ebarb_far.sv */
// Far end: external master or external arbiter facing the device
module ebarb_far import ebarb_pkg::*; (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // Configuration: high when the device's arbiter is enabled
    input wire logic arb_en,
    // Transaction request
    input wire logic req_valid,
    output logic req_ready,
    input wire logic [EBARB_ADDR_W-1:0] req_addr,
    input wire ebarb_attr_t req_attr,
    input wire logic [EBARB_DATA_W-1:0] beat_data,
    output logic beat_take,
    output logic xfer_done,
    // Bus
    ebarb_if.far_mp bus
);

    typedef struct packed {
        logic clk_prev;
        ebarb_state_t st;
        ebarb_attr_t attr;
        logic [EBARB_ADDR_W-1:0] addr;
        logic [EBARB_DATA_W-1:0] data;
        logic [EBARB_BEAT_W-1:0] left;
        logic grant;
        logic seen;
        logic br;
        logic bb;
        logic own;
        logic start;
        logic beat;
        logic done;
    } ebarb_far_t;

    ebarb_far_t q;
    ebarb_far_t d;

    logic en;
    logic dev_req;
    logic granted_in;
    logic busy_in;

    // Step on each rising edge of the device's bus clock
    assign en = bus.bus_clock_out & ~q.clk_prev; // R9
    assign dev_req = ~bus.bus_request_n;
    assign granted_in = ~bus.bus_grant_n;
    assign busy_in = ~bus.bus_busy_n;

    assign req_ready = en && (q.st == ST_IDLE);
    assign beat_take = en && (((q.st == ST_ADDR) && q.attr.has_data)
                       || ((q.st == ST_DATA) && (q.left != EBARB_BEAT_ONE)));

    always_comb begin
        d = q;
        d.done = 1'b0;
        d.clk_prev = bus.bus_clock_out;
        if (en) begin
            // External arbiter role when the device's arbiter is off
            if (!arb_en) begin
                if (!q.grant) begin
                    if (dev_req && !busy_in && q.st == ST_IDLE && !req_valid) begin
                        d.grant = 1'b1;
                    end
                end else if (!q.seen) begin
                    if (busy_in) begin
                        d.seen = 1'b1;
                    end else if (!dev_req) begin
                        d.grant = 1'b0;
                    end
                end else if (!busy_in) begin
                    d.grant = 1'b0;
                    d.seen = 1'b0;
                end
            end else begin
                d.grant = 1'b0;
                d.seen = 1'b0;
            end
            unique case (q.st)
                ST_IDLE: begin
                    if (req_valid) begin
                        d.addr = req_addr;
                        d.attr = req_attr;
                        d.st = ST_ARB; // R10
                    end
                end
                ST_ARB: begin
                    if (arb_en) begin
                        d.br = 1'b1; // R13
                        if (granted_in && !busy_in) begin // R2
                            d.br = 1'b0;
                            d.bb = 1'b1;
                            d.own = 1'b1;
                            d.start = 1'b1; // R11
                            d.st = ST_ADDR;
                        end
                    end else if (!q.grant && !busy_in) begin
                        d.bb = 1'b1;
                        d.own = 1'b1;
                        d.start = 1'b1; // R11
                        d.st = ST_ADDR;
                    end
                end
                ST_ADDR: begin
                    d.start = 1'b0;
                    if (q.attr.has_data) begin // R11
                        d.data = beat_data;
                        d.beat = 1'b1;
                        d.left = ebarb_beats(q.attr.kind); // R12
                        d.st = ST_DATA;
                    end else begin
                        d.st = ST_TERM;
                    end
                end
                ST_DATA: begin
                    if (q.left == EBARB_BEAT_ONE) begin
                        d.beat = 1'b0;
                        d.st = ST_TERM; // R10
                    end else begin
                        d.left = q.left - 1'b1; // R12
                        d.data = beat_data;
                    end
                end
                ST_TERM: begin
                    d.bb = 1'b0;
                    d.own = 1'b0;
                    d.done = 1'b1;
                    d.st = ST_IDLE;
                end
                default: begin
                    d.st = ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign bus.far_br_o = 1'b0;
    assign bus.far_br_oe = q.br;
    assign bus.far_bg_o = 1'b0;
    assign bus.far_bg_oe = q.grant;
    assign bus.far_bb_o = 1'b0;
    assign bus.far_bb_oe = q.bb;
    assign bus.far_own_oe = q.own;
    assign bus.far_start_n_o = ~q.start;
    assign bus.far_beat_n_o = ~q.beat;
    assign bus.far_addr_o = q.addr;
    assign bus.far_attr_o = q.attr;
    assign bus.far_data_o = q.data;
    assign xfer_done = q.done;

endmodule

/* File: sim/ebarb_assertions.sv */
// Concurrent checks on the shared wires of the arbitration link
module ebarb_assertions import ebarb_pkg::*; #(
    parameter int BUS_DIV = EBARB_BUS_DIV_DEF
) (
    // Clock, reset and mode
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic arb_en,
    // Pin enables
    input wire logic dev_br_oe,
    input wire logic dev_bg_oe,
    input wire logic dev_bb_oe,
    input wire logic far_bb_oe,
    input wire logic dev_own_oe,
    // Resolved bus
    input wire logic bus_clock_out,
    input wire logic bus_request_n,
    input wire logic bus_grant_n,
    input wire logic bus_busy_n,
    input wire logic bus_start_n,
    input wire logic bus_beat_n,
    input wire ebarb_attr_t bus_attr
);
    localparam int STEP = BUS_DIV;
    logic ck_prev_q;
    logic ck_seen_q;
    logic [7:0] ck_cnt_q;
    logic [7:0] beat_cyc_q;
    logic [7:0] beat_exp_q;
    logic rise;
    logic [7:0] n_beats;

    assign rise = bus_clock_out & ~ck_prev_q;
    assign n_beats = (bus_attr.kind == EBARB_SINGLE) ? 8'h01 : (8'h02 << bus_attr.kind);

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            ck_prev_q <= 1'b0;
            ck_seen_q <= 1'b0;
            ck_cnt_q <= 8'h00;
            beat_cyc_q <= 8'h00;
            beat_exp_q <= 8'h00;
        end else begin
            ck_prev_q <= bus_clock_out;
            ck_seen_q <= ck_seen_q | rise;
            ck_cnt_q <= rise ? 8'h01 : ck_cnt_q + 8'h01;
            beat_cyc_q <= bus_beat_n ? 8'h00 : beat_cyc_q + 8'h01;
            if (!bus_start_n) begin
                beat_exp_q <= bus_attr.has_data ? 8'(n_beats * STEP) : 8'h00;
            end
        end
    end

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);

    sequence addr_step;
        $fell(bus_start_n) ##0 !bus_busy_n;
    endsequence
    sequence data_step;
        bus_start_n && !bus_beat_n;
    endsequence

    a_clock_period: assert property (rise && ck_seen_q |-> ck_cnt_q == 8'(STEP))
        else $error("bus clock period wrong");
    a_step_aligned: assert property ($changed({bus_busy_n, bus_grant_n, bus_request_n,
        bus_start_n, bus_beat_n}) |-> $past(rise)) else $error("bus line moved off a step");
    a_grant_requested: assert property ($fell(bus_grant_n) |-> $past(!bus_request_n))
        else $error("grant without request");
    a_pin_direction: assert property (dev_bg_oe || dev_br_oe |-> dev_bg_oe == arb_en)
        else $error("arbitration pin driven in wrong mode");
    a_dev_qualified: assert property (!arb_en && $rose(dev_bb_oe)
        |-> $past(!bus_grant_n && bus_busy_n)) else $error("device took bus unqualified");
    a_far_qualified: assert property (arb_en && $rose(far_bb_oe)
        |-> $past(!bus_grant_n && bus_busy_n)) else $error("master took bus unqualified");
    a_owner_busy: assert property (dev_own_oe |-> dev_bb_oe && !bus_busy_n)
        else $error("owner not holding busy");
    a_tenure_end: assert property (arb_en && $rose(bus_busy_n) |-> ##[0:STEP] !dev_bg_oe)
        else $error("grant kept after tenure");
    a_addr_data: assert property (addr_step ##0 bus_attr.has_data |-> ##STEP data_step)
        else $error("data phase missing after address");
    a_no_data_skip: assert property (addr_step ##0 !bus_attr.has_data
        |-> ##STEP bus_start_n && bus_beat_n) else $error("beat without data");
    a_beat_count: assert property ($rose(bus_beat_n)
        |-> beat_cyc_q == beat_exp_q && !bus_busy_n) else $error("beat count wrong");
endmodule

/* File: sim/tb_top.sv */
// Bench joining the device end and the far end over the shared bus
module tb_top import ebarb_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int DIV = 2;
    typedef struct packed {
        logic arb;
        logic far;
        logic has_data;
        ebarb_kind_t kind;
    } ebarb_row_t;
    ebarb_row_t rows [12] = '{'{1, 0, 1, EBARB_SINGLE}, '{1, 0, 1, EBARB_BURST4},
        '{1, 0, 1, EBARB_BURST8}, '{1, 0, 1, EBARB_BURST16}, '{1, 0, 0, EBARB_SINGLE},
        '{1, 1, 1, EBARB_BURST16}, '{1, 1, 1, EBARB_SINGLE}, '{0, 0, 1, EBARB_BURST8},
        '{0, 0, 0, EBARB_BURST4}, '{0, 1, 1, EBARB_BURST4}, '{0, 0, 1, EBARB_BURST16},
        '{1, 1, 0, EBARB_BURST8}};
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic arb_en = 1'b1;
    logic rq_valid [2] = '{1'b0, 1'b0};
    logic [31:0] rq_addr [2] = '{32'h0, 32'h0};
    ebarb_attr_t rq_attr [2] = '{3'h0, 3'h0};
    logic [31:0] bt_data [2] = '{32'h0, 32'h0};
    logic [31:0] bt_base [2] = '{32'h0, 32'h0};
    logic rq_ready [2];
    logic bt_take [2];
    logic done [2];
    logic rx_addr_valid;
    logic [31:0] rx_addr;
    ebarb_attr_t rx_attr;
    logic rx_data_valid;
    logic [31:0] rx_data;
    logic ck_prev = 1'b0;
    logic [31:0] seen_words [$];
    logic [31:0] rx_words [$];
    logic [31:0] seen_addr;
    ebarb_attr_t seen_attr;
    int takes [2] = '{0, 0};
    int done_cnt [2] = '{0, 0};
    int done_goal [2] = '{0, 0};
    int fail_count = 0;
    int samples_checked = 0;
    int cycles = 0;
    int rx_av_cnt = 0;

    ebarb_if bus ();
    ebarb_dev #(.BUS_DIV(DIV)) u_ebarb_dev (.sys_clk(sys_clk), .rstn(rstn), .arb_en(arb_en),
        .req_valid(rq_valid[0]), .req_ready(rq_ready[0]), .req_addr(rq_addr[0]),
        .req_attr(rq_attr[0]), .beat_data(bt_data[0]), .beat_take(bt_take[0]),
        .xfer_done(done[0]), .rx_addr_valid(rx_addr_valid), .rx_addr(rx_addr),
        .rx_attr(rx_attr), .rx_data_valid(rx_data_valid), .rx_data(rx_data), .bus(bus));
    ebarb_far u_ebarb_far (.sys_clk(sys_clk), .rstn(rstn), .arb_en(arb_en),
        .req_valid(rq_valid[1]), .req_ready(rq_ready[1]), .req_addr(rq_addr[1]),
        .req_attr(rq_attr[1]), .beat_data(bt_data[1]), .beat_take(bt_take[1]),
        .xfer_done(done[1]), .bus(bus));
    ebarb_assertions #(.BUS_DIV(DIV)) u_ebarb_assertions (.sys_clk(sys_clk), .rstn(rstn),
        .arb_en(arb_en), .dev_br_oe(bus.dev_br_oe), .dev_bg_oe(bus.dev_bg_oe),
        .dev_bb_oe(bus.dev_bb_oe), .far_bb_oe(bus.far_bb_oe), .dev_own_oe(bus.dev_own_oe),
        .bus_clock_out(bus.bus_clock_out), .bus_request_n(bus.bus_request_n),
        .bus_grant_n(bus.bus_grant_n), .bus_busy_n(bus.bus_busy_n),
        .bus_start_n(bus.bus_start_n), .bus_beat_n(bus.bus_beat_n), .bus_attr(bus.bus_attr));

    always #2.5 sys_clk = ~sys_clk;

    // Next beat word is the base plus the number of words already taken
    // A take is consumed at the coming rising edge, so the word moves on after it
    always @(negedge sys_clk) begin
        for (int e = 0; e < 2; e++) begin
            if (bt_take[e] === 1'b1) begin
                takes[e]++;
            end else begin
                bt_data[e] = bt_base[e] + 32'(takes[e]);
            end
        end
    end

    // Bus lines are read once per bus step, as the ends see them
    always @(posedge sys_clk) begin
        ck_prev <= bus.bus_clock_out;
        cycles++;
        for (int e = 0; e < 2; e++) begin
            if (done[e] === 1'b1) begin
                done_cnt[e]++;
            end
        end
        if (rx_data_valid === 1'b1) begin
            rx_words.push_back(rx_data);
        end
        if (rx_addr_valid === 1'b1) begin
            rx_av_cnt++;
        end
        if (bus.bus_clock_out && !ck_prev) begin
            if (bus.bus_beat_n === 1'b0) begin
                seen_words.push_back(bus.bus_data);
            end
            if (bus.bus_start_n === 1'b0) begin
                seen_addr = bus.bus_addr;
                seen_attr = bus.bus_attr;
            end
        end
        if (cycles == 20000) begin
            fail_count++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        $display("Mismatches %0d, comparisons %0d", fail_count, samples_checked);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic check32(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic do_reset(input logic arb);
        @(negedge sys_clk);
        rstn = 1'b0;
        arb_en = arb;
        repeat (2) @(negedge sys_clk);
        check32(32'({bus.bus_busy_n, bus.bus_grant_n, bus.bus_request_n, bus.bus_start_n,
            rq_ready[0], rq_ready[1]}), 32'h3C);
        rstn = 1'b1;
    endtask

    task automatic start_req(input int e, input logic [31:0] a, input ebarb_attr_t at);
        int n;
        n = 0;
        seen_words.delete();
        rx_words.delete();
        rx_av_cnt = 0;
        rq_addr[e] = a;
        rq_attr[e] = at;
        bt_base[e] = a ^ 32'h5A5A0000;
        bt_data[e] = bt_base[e];
        takes[e] = 0;
        done_goal[e] = done_cnt[e] + 1;
        rq_valid[e] = 1'b1;
        #1;
        while (rq_ready[e] !== 1'b1 && n < 200) begin
            @(negedge sys_clk);
            #1;
            n++;
        end
        @(negedge sys_clk);
        rq_valid[e] = 1'b0;
    endtask

    task automatic wait_done(input int e);
        int n;
        n = 0;
        while (done_cnt[e] < done_goal[e] && n < 400) begin
            @(negedge sys_clk);
            n++;
        end
        check32(32'(done_cnt[e]), 32'(done_goal[e]));
    endtask

    task automatic expect_words(input int e, input ebarb_attr_t at);
        int nb;
        nb = at.has_data ? ((at.kind == EBARB_SINGLE) ? 1 : (2 << int'(at.kind))) : 0;
        check32(32'(takes[e]), 32'(nb));
        check32(32'(seen_words.size()), 32'(nb));
        check32(seen_addr, rq_addr[e]);
        check32(32'(seen_attr), 32'(at));
        for (int i = 0; i < nb; i++) begin
            check32(seen_words[i], bt_base[e] + 32'(i));
        end
        if (e == 1) begin
            check32(rx_addr, rq_addr[1]);
            check32(32'(rx_attr), 32'(at));
            check32(32'(rx_av_cnt), 32'h1);
            check32(32'(rx_words.size()), 32'(nb));
            for (int i = 0; i < nb; i++) begin
                check32(rx_words[i], bt_base[1] + 32'(i));
            end
        end
    endtask

    initial begin
        int e;
        ebarb_attr_t at;
        do_reset(1'b1);
        foreach (rows[i]) begin
            if (rows[i].arb !== arb_en) begin
                do_reset(rows[i].arb);
            end
            e = rows[i].far ? 1 : 0;
            at = {rows[i].has_data, rows[i].kind};
            start_req(e, 32'h10000000 + 32'(i * 16), at);
            wait_done(e);
            expect_words(e, at);
        end
        // Both ends ask at once; the device's own request goes first
        fork
            start_req(0, 32'h20000000, 3'h4);
            start_req(1, 32'h30000000, 3'h4);
        join
        wait_done(0);
        wait_done(1);
        check32(32'(seen_words.size()), 32'h2);
        check32(seen_words[0], bt_base[0]);
        check32(seen_words[1], bt_base[1]);
        // Reset in mid-burst, then a clean transfer
        start_req(0, 32'h40000000, 3'h7);
        repeat (12) @(negedge sys_clk);
        do_reset(1'b1);
        start_req(0, 32'h50000000, 3'h5);
        wait_done(0);
        expect_words(0, 3'h5);
        print_verdict();
    end
endmodule
